// [logic/an_page_pkg.sv]
// Constants, register map and types for the base page codec transmit block.
// Notes on behaviour
// - Full duplex ability sits in bit D5.
// - Half duplex ability sits in bit D6.
// - Pause bits D7/D8 encode four pause modes.
// - Asymmetric pause enables receive and transmit separately.
// - Remote fault in D12/D13, default zero.
// - Fault codes: ok, offline, link failure, negotiation error.
// - No fault support means always send zero.
// - Sent fault held until base idle-detect, then cleared.
// - Received nonzero fault sets status fault bit.
// - Fault signalling hidden while sync fails.
// - Long all-zero reception means link failure.
// - Failed resolution advertises negotiation error code.
// - Ack flag sits in bit D14.
// - Ack after three identical words, Ack ignored.
// - Next page Ack kept until new page loaded.
// - Word held for link timer after complete-ack.
// - NP set requests more pages, clear ends.
// - Base page NP clear declines next pages.
// - Restart sends zero words, then base page.
// - Never advertise an ability not possessed.
// - Word from advertisement or next page register.
// - Xmit picks configuration, idle or data output.
// - Reserved bits D0-D4, D9-D11 sent zero.
// - NP flag sits in bit D15.
package an_page_pkg;
  // Configuration word bit positions
  localparam int BIT_FD = 5;
  localparam int BIT_HD = 6;
  localparam int BIT_PAUSE = 7;
  localparam int BIT_ASM = 8;
  localparam int BIT_RF_LO = 12;
  localparam int BIT_ACK = 14;
  localparam int BIT_NP = 15;
  // Bits that may be set in a base page apart from Ack; reserved ones excluded
  localparam logic [15:0] BASE_MASK = 16'hB1E0;
  localparam logic [15:0] ACK_MASK = 16'h4000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  // Remote fault codes (RF1 is the low bit D12)
  localparam logic [1:0] RF_OK = 2'h0;
  localparam logic [1:0] RF_OFFLINE = 2'h2;
  localparam logic [1:0] RF_LINK_FAIL = 2'h1;
  localparam logic [1:0] RF_AN_ERROR = 2'h3;
  // Register byte offsets
  localparam logic [7:0] OFF_ADV = 8'h00;
  localparam logic [7:0] OFF_NPTX = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PARTNER = 8'h10;
  // Control register fields
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_NP_PHASE = 1;
  // Reset values
  localparam logic [15:0] ADV_RST = 16'h0000;
  localparam logic [15:0] NPTX_RST = 16'h0000;
  // Match count that grants Ack
  localparam logic [1:0] ACK_MATCHES = 2'h3;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int LINK_TIMER_US = 10_000;
  localparam int LINK_TIMER_CYC = (LINK_TIMER_US / 1000) * (CLK_HZ / 1000);
  // Transmit selection from the arbitration side
  typedef enum logic [1:0] {XMIT_IDLE, XMIT_CONFIG, XMIT_DATA} xmit_t;
  // Output kind toward the ordered-set encoder
  typedef enum logic [1:0] {KIND_IDLE, KIND_CONFIG, KIND_DATA} tx_kind_t;
  // Word source phase after a restart
  typedef enum logic {PH_ZEROS, PH_PAGE} tx_phase_t;
endpackage

// [logic/an_page_codec.sv]
// Base page codec: builds the transmitted configuration word and tracks received words.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module an_page_codec #(
  parameter int LINK_TIMER_CYC = an_page_pkg::LINK_TIMER_CYC, // Link timer in cycles
  parameter logic [15:0] ABILITY = an_page_pkg::BASE_MASK,    // Abilities the device has
  parameter bit RF_SUPPORT = 1'b1                             // Fault sensing present
) (
  input wire logic SYS_CLK,                 // 10 MHz clock
  input wire logic ARST_N,                  // Async reset, active low
  input wire logic CE,                      // Clock enable, freezes all state but the reset synchroniser when low
  input wire logic PSEL,                    // APB select
  input wire logic PENABLE,                 // APB access phase
  input wire logic PWRITE,                  // APB direction
  input wire logic [7:0] PADDR,             // APB byte address
  input wire logic [31:0] PWDATA,           // APB write data
  output logic [31:0] PRDATA,               // APB read data
  output logic PREADY,                      // APB ready
  output logic PSLVERR,                     // APB error on unmapped address
  input wire logic [1:0] XMIT,              // Transmit selection from arbitration
  input wire logic RX_CFG_VALID,            // One received configuration word
  input wire logic [15:0] RX_CFG_WORD,      // Received configuration word
  input wire logic SYNC_OK,                 // Receive synchronisation good
  input wire logic IDLE_DETECT,             // Arbitration entered idle-detect
  input wire logic CMPL_ACK,                // Arbitration entered complete-ack
  input wire logic RESOLVE_FAIL,            // Resolution found no common mode
  output logic [1:0] TX_KIND,               // Ordered-set kind to send
  output logic [15:0] TX_CFG_WORD,          // Configuration word to send
  output logic RF_STATUS,                   // Partner fault seen, sync gated
  output logic PAUSE_TX_EN,                 // Resolved pause transmit enable
  output logic PAUSE_RX_EN                  // Resolved pause receive enable
);
  localparam int TW = $clog2(LINK_TIMER_CYC + 1);
  localparam logic [TW-1:0] LT_MAX = TW'(LINK_TIMER_CYC - 1);

  logic rst_s1_r, rst_n_r;                  // Reset release synchroniser
  logic [15:0] adv_r;                       // Advertisement register
  logic [15:0] nptx_r;                      // Next page transmit register
  logic np_phase_r;                         // Next page exchange active
  logic np_loaded_r;                        // Fresh next page loaded
  logic restart_r;                          // Restart request pulse
  logic [1:0] rf_tx_r;                      // Remote fault code being sent
  logic rf_rx_r;                            // Partner fault seen, sticky
  logic ack_r;                              // Our Ack bit
  logic [1:0] match_cnt_r;                  // Consecutive identical receptions
  logic [15:0] rx_prev_r;                   // Last received word
  logic [15:0] partner_r;                   // Last received base page
  logic [TW-1:0] zero_rx_cnt_r;             // Length of all-zero reception
  logic link_fail_r;                        // All-zero run exceeded link timer
  an_page_pkg::tx_phase_t phase_r;          // Zero words or page
  logic [TW-1:0] zero_tx_cnt_r;             // Restart zero words sent
  logic [TW-1:0] hold_cnt_r;                // Complete-ack hold time left
  logic hold_r;                             // Word frozen after complete-ack
  logic [15:0] word_nxt;                    // Word the logic would send now
  logic wr_acc, rd_acc;                     // Completed APB accesses
  logic addr_ok;                            // Address decodes to a register
  logic [31:0] rdata_nxt;                   // Read mux
  logic rf_ev;                              // Any fault source this cycle
  logic [1:0] rf_ev_code;                   // Its code
  logic same_word;                          // Received word repeats, Ack ignored
  logic np_load;                            // Next page register written this cycle

  // Pause resolution of local and partner bits; returns {tx_en, rx_en}
  function automatic logic [1:0] pause_res(input logic lp, input logic la,
                                           input logic rp, input logic ra);
    logic [1:0] r;
    r = 2'b00;
    if (lp && rp) begin
      r = 2'b11;
    end else if (!lp && la && rp && ra) begin
      r = 2'b10;
    end else if (lp && la && !rp && ra) begin
      r = 2'b01;
    end
    return r;
  endfunction

  // Reset is released through two flops; assert is immediate
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // APB decode; the slave is always ready, so every access is one wait-free cycle
  assign wr_acc = PSEL && PENABLE && PWRITE && CE;
  assign rd_acc = PSEL && PENABLE && !PWRITE && CE;
  assign addr_ok = (PADDR == an_page_pkg::OFF_ADV) || (PADDR == an_page_pkg::OFF_NPTX) ||
                   (PADDR == an_page_pkg::OFF_CTRL) || (PADDR == an_page_pkg::OFF_STATUS) ||
                   (PADDR == an_page_pkg::OFF_PARTNER);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // Read mux; status fault bit hidden while sync fails
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (PADDR)
      an_page_pkg::OFF_ADV: rdata_nxt = {16'h0000, adv_r};
      an_page_pkg::OFF_NPTX: rdata_nxt = {16'h0000, nptx_r};
      an_page_pkg::OFF_CTRL: rdata_nxt = {30'h0000_0000, np_phase_r, 1'b0};
      an_page_pkg::OFF_STATUS: rdata_nxt = {21'h00_0000, PAUSE_RX_EN, PAUSE_TX_EN,
                                            np_loaded_r, match_cnt_r,
                                            (phase_r == an_page_pkg::PH_ZEROS), link_fail_r,
                                            ack_r, rf_rx_r && SYNC_OK, rf_tx_r};
      an_page_pkg::OFF_PARTNER: rdata_nxt = {16'h0000, partner_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data comes from a flop, loaded in the setup cycle
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      PRDATA <= 32'h0000_0000;
    end else if (CE && PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rdata_nxt;
    end
  end

  // Software registers; abilities the device lacks cannot be written
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      adv_r <= an_page_pkg::ADV_RST;
      nptx_r <= an_page_pkg::NPTX_RST;
      np_phase_r <= 1'b0;
      restart_r <= 1'b0;
    end else if (CE) begin
      restart_r <= wr_acc && (PADDR == an_page_pkg::OFF_CTRL) &&
                   PWDATA[an_page_pkg::CTRL_RESTART];
      if (wr_acc && PADDR == an_page_pkg::OFF_ADV) begin
        adv_r <= PWDATA[15:0] & ABILITY & an_page_pkg::BASE_MASK & ~an_page_pkg::ACK_MASK;
      end
      if (wr_acc && PADDR == an_page_pkg::OFF_NPTX) begin
        nptx_r <= PWDATA[15:0];
      end
      if (wr_acc && PADDR == an_page_pkg::OFF_CTRL) begin
        np_phase_r <= PWDATA[an_page_pkg::CTRL_NP_PHASE];
      end
    end
  end

  // Next page loaded flag: set by a write, cleared on the first clock edge after it that finds Ack high
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      np_loaded_r <= 1'b0;
    end else if (CE) begin
      if (wr_acc && PADDR == an_page_pkg::OFF_NPTX) begin
        np_loaded_r <= 1'b1;
      end else if (ack_r && np_loaded_r) begin
        np_loaded_r <= 1'b0;
      end
    end
  end

  // Received-word comparison excludes the Ack bit
  assign same_word = ((RX_CFG_WORD ^ rx_prev_r) & ~an_page_pkg::ACK_MASK) == 16'h0000;
  assign np_load = wr_acc && (PADDR == an_page_pkg::OFF_NPTX);

  // Match counter and partner capture
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      match_cnt_r <= 2'h0;
      rx_prev_r <= an_page_pkg::WORD_ZERO;
      partner_r <= an_page_pkg::WORD_ZERO;
    end else if (CE) begin
      if (restart_r) begin
        match_cnt_r <= 2'h0;
      end else if (RX_CFG_VALID) begin
        rx_prev_r <= RX_CFG_WORD;
        // A word arriving with a page load counts as the first of a new run
        if (!same_word || match_cnt_r == 2'h0 || np_load) begin
          match_cnt_r <= 2'h1;
        end else if (match_cnt_r != an_page_pkg::ACK_MATCHES) begin
          match_cnt_r <= match_cnt_r + 2'h1;
        end
        if (!np_phase_r && RX_CFG_WORD != an_page_pkg::WORD_ZERO) begin
          partner_r <= RX_CFG_WORD;
        end
      end else if (np_load) begin
        // A fresh next page restarts the run, otherwise Ack could never drop
        match_cnt_r <= 2'h0;
      end
    end
  end

  // Ack: set after three matches; in next page exchange held until a new page loads
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
    end else if (CE) begin
      if (restart_r) begin
        ack_r <= 1'b0;
      end else if (match_cnt_r == an_page_pkg::ACK_MATCHES) begin
        ack_r <= 1'b1;
      end else if (np_phase_r && np_loaded_r) begin
        ack_r <= 1'b0;
      end else if (!np_phase_r && match_cnt_r != an_page_pkg::ACK_MATCHES) begin
        ack_r <= 1'b0;
      end
    end
  end

  // All-zero reception timer; exceeding the link timer flags link failure
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      zero_rx_cnt_r <= '0;
      link_fail_r <= 1'b0;
    end else if (CE) begin
      if (RX_CFG_VALID && RX_CFG_WORD != an_page_pkg::WORD_ZERO) begin
        zero_rx_cnt_r <= '0;
        link_fail_r <= 1'b0;
      end else if (zero_rx_cnt_r == LT_MAX && RX_CFG_VALID) begin
        link_fail_r <= 1'b1;
      end else if (RX_CFG_VALID) begin
        zero_rx_cnt_r <= zero_rx_cnt_r + 1'b1;
      end
    end
  end

  // Fault sources, most severe first
  always_comb begin
    rf_ev = 1'b1;
    rf_ev_code = an_page_pkg::RF_OK;
    if (RESOLVE_FAIL) begin
      rf_ev_code = an_page_pkg::RF_AN_ERROR;
    end else if (link_fail_r) begin
      rf_ev_code = an_page_pkg::RF_LINK_FAIL;
    end else if (wr_acc && PADDR == an_page_pkg::OFF_ADV &&
                 PWDATA[an_page_pkg::BIT_RF_LO+1 -: 2] != an_page_pkg::RF_OK) begin
      rf_ev_code = PWDATA[an_page_pkg::BIT_RF_LO+1 -: 2];
    end else begin
      rf_ev = 1'b0;
    end
  end

  // Sent fault code: held until base idle-detect; a new fault wins over the clear
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rf_tx_r <= an_page_pkg::RF_OK;
    end else if (CE) begin
      if (!RF_SUPPORT) begin
        rf_tx_r <= an_page_pkg::RF_OK;
      end else if (rf_ev) begin
        rf_tx_r <= rf_ev_code;
      end else if (IDLE_DETECT && !np_phase_r) begin
        rf_tx_r <= an_page_pkg::RF_OK;
      end
    end
  end

  // Partner fault sticky; cleared by status read, a new one wins
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rf_rx_r <= 1'b0;
    end else if (CE) begin
      if (RX_CFG_VALID && !np_phase_r &&
          RX_CFG_WORD[an_page_pkg::BIT_RF_LO+1 -: 2] != an_page_pkg::RF_OK) begin
        rf_rx_r <= 1'b1;
      end else if (rd_acc && PADDR == an_page_pkg::OFF_STATUS && SYNC_OK) begin
        rf_rx_r <= 1'b0;
      end
    end
  end
  assign RF_STATUS = rf_rx_r && SYNC_OK;

  // Restart: zero words for one link timer, then the page
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      phase_r <= an_page_pkg::PH_ZEROS;
      zero_tx_cnt_r <= '0;
    end else if (CE) begin
      if (restart_r) begin
        phase_r <= an_page_pkg::PH_ZEROS;
        zero_tx_cnt_r <= '0;
      end else if (phase_r == an_page_pkg::PH_ZEROS) begin
        if (zero_tx_cnt_r == LT_MAX) begin
          phase_r <= an_page_pkg::PH_PAGE;
        end else begin
          zero_tx_cnt_r <= zero_tx_cnt_r + 1'b1;
        end
      end
    end
  end

  // Complete-ack hold for the link timer
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hold_r <= 1'b0;
      hold_cnt_r <= '0;
    end else if (CE) begin
      if (restart_r) begin
        hold_r <= 1'b0;
      end else if (CMPL_ACK && !hold_r) begin
        hold_r <= 1'b1;
        hold_cnt_r <= LT_MAX;
      end else if (hold_r && hold_cnt_r == '0) begin
        hold_r <= 1'b0;
      end else if (hold_r) begin
        hold_cnt_r <= hold_cnt_r - 1'b1;
      end
    end
  end

  // Word source: zeros, base page fields, or next page register
  always_comb begin
    word_nxt = an_page_pkg::WORD_ZERO;
    if (phase_r == an_page_pkg::PH_PAGE && np_phase_r) begin
      word_nxt = nptx_r;
      word_nxt[an_page_pkg::BIT_ACK] = ack_r;
    end else if (phase_r == an_page_pkg::PH_PAGE) begin
      word_nxt[an_page_pkg::BIT_FD] = adv_r[an_page_pkg::BIT_FD];
      word_nxt[an_page_pkg::BIT_HD] = adv_r[an_page_pkg::BIT_HD];
      word_nxt[an_page_pkg::BIT_PAUSE] = adv_r[an_page_pkg::BIT_PAUSE];
      word_nxt[an_page_pkg::BIT_ASM] = adv_r[an_page_pkg::BIT_ASM];
      word_nxt[an_page_pkg::BIT_RF_LO+1 -: 2] = rf_tx_r;
      word_nxt[an_page_pkg::BIT_ACK] = ack_r;
      word_nxt[an_page_pkg::BIT_NP] = adv_r[an_page_pkg::BIT_NP];
    end
  end

  // Output word and kind; the word freezes during the complete-ack hold
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      TX_CFG_WORD <= an_page_pkg::WORD_ZERO;
      TX_KIND <= 2'(an_page_pkg::KIND_IDLE);
    end else if (CE) begin
      if (!hold_r) begin
        // Ack is not a reserved bit, so it passes the base page mask
        TX_CFG_WORD <= word_nxt & (np_phase_r ? 16'hFFFF :
                                   (an_page_pkg::BASE_MASK | an_page_pkg::ACK_MASK));
      end
      unique case (an_page_pkg::xmit_t'(XMIT))
        an_page_pkg::XMIT_CONFIG: TX_KIND <= 2'(an_page_pkg::KIND_CONFIG);
        an_page_pkg::XMIT_DATA: TX_KIND <= 2'(an_page_pkg::KIND_DATA);
        default: TX_KIND <= 2'(an_page_pkg::KIND_IDLE);
      endcase
    end
  end

  // Pause resolution from our advertisement and partner base page
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      PAUSE_TX_EN <= 1'b0;
      PAUSE_RX_EN <= 1'b0;
    end else if (CE) begin
      {PAUSE_TX_EN, PAUSE_RX_EN} <= pause_res(adv_r[an_page_pkg::BIT_PAUSE],
                                              adv_r[an_page_pkg::BIT_ASM],
                                              partner_r[an_page_pkg::BIT_PAUSE],
                                              partner_r[an_page_pkg::BIT_ASM]);
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n_r);

  ack_three_a: assert property (CE && !restart_r && match_cnt_r == 2'h3 |=> ack_r)
    else $error("ack not set after three matches");
  ack_early_a: assert property ($rose(ack_r) |-> $past(match_cnt_r) == 2'h3)
    else $error("ack rose too early");
  count_reset_a: assert property (CE && !restart_r && RX_CFG_VALID && !same_word
                                  |=> match_cnt_r == 2'h1)
    else $error("match count not restarted");
  rf_hold_a: assert property (CE && RF_SUPPORT && !rf_ev && !(IDLE_DETECT && !np_phase_r)
                              |=> rf_tx_r == $past(rf_tx_r))
    else $error("fault code changed without cause");
  rf_clear_a: assert property (CE && IDLE_DETECT && !np_phase_r && !rf_ev
                               |=> rf_tx_r == 2'h0)
    else $error("fault code not cleared at idle detect");
  rf_gate_a: assert property (!SYNC_OK |-> !RF_STATUS)
    else $error("fault shown while sync failed");
  rf_err_a: assert property (CE && RF_SUPPORT && RESOLVE_FAIL |=> rf_tx_r == 2'h3)
    else $error("negotiation error not advertised");
  reserved_a: assert property (!np_phase_r && !$past(np_phase_r) && !hold_r
                               |-> (TX_CFG_WORD & 16'h0E1F) == 16'h0000)
    else $error("reserved bits sent nonzero");
  hold_word_a: assert property (hold_r && $past(hold_r) |-> $stable(TX_CFG_WORD))
    else $error("word changed during hold");
  zeros_a: assert property (CE && restart_r |=> ##1 TX_CFG_WORD == 16'h0000 || !CE)
    else $error("restart did not send zeros");
  kind_a: assert property (CE && XMIT == 2'(an_page_pkg::XMIT_CONFIG)
                           |=> TX_KIND == 2'(an_page_pkg::KIND_CONFIG))
    else $error("config kind not selected");

  ack_cov_c: cover property (CE && RX_CFG_VALID ##[1:20] $rose(ack_r));
  rf_cov_c: cover property ($rose(rf_rx_r) ##[1:20] rf_tx_r == 2'h0);
  hold_cov_c: cover property ($rose(hold_r));
  np_cov_c: cover property (np_phase_r && $fell(ack_r));
endmodule // an_page_codec

// [tb/an_partner.sv]
// Link partner model: sends configuration words and acknowledges the device.
`timescale 1ns/10ps
module an_partner (
  input wire logic clk, // PCS clock
  input wire logic rst_n, // Reset, active low
  input wire logic send, // Send one word each cycle
  input wire logic [15:0] word, // Page to send, Ack position unused
  input wire logic [15:0] tx_word, // Word the device sends
  output logic valid, // Word strobe
  output logic [15:0] rx_word // Word on the link
);
  logic [15:0] last_r; // Last device word without Ack
  logic [1:0] seen_r; // Identical device words seen, saturating
  // Count identical device words; a differing one restarts at one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= '0;
      seen_r <= '0;
    end else begin
      last_r <= tx_word & ~an_page_pkg::ACK_MASK;
      if ((tx_word & ~an_page_pkg::ACK_MASK) != last_r) seen_r <= 2'h1;
      else if (seen_r != 2'h3) seen_r <= seen_r + 2'h1;
    end
  end
  // Idle line inverts its previous value every cycle so nothing stale passes for data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 1'b0;
      rx_word <= '0;
    end else begin
      valid <= send;
      // Restart zeros never carry Ack
      rx_word <= send ? {word[15], seen_r == 2'h3 && word != 0, word[13:0]} : ~rx_word;
    end
  end
endmodule // an_partner

// [tb/tb_top.sv]
// Self-checking testbench for the base page codec.
`timescale 1ns/10ps
module tb_top;
  localparam int LT = 8; // Shortened link timer
  localparam logic [15:0] ABIL = 16'hB1A0; // Half duplex not possessed
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, sync = 1, idet = 0, cack = 0;
  logic rfail = 0, psend = 0, ce = 1, rxv, pready, pslverr, rfst, ptx, prx, e;
  logic [1:0] xmit = 2'h1, kind;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [15:0] pword = 0, rxw, txw;
  int err_count = 0, tests_run = 0, cyc = 0;
  // Rows: xmit, kind, local pause/asm, partner pause/asm, pause tx/rx
  logic [9:0] rows [9] = '{10'h00C, 10'h154, 10'h298, 10'h31E, 10'h024,
                           10'h16B, 10'h2B0, 10'h335, 10'h17B};
  logic [15:0] sq [5] = '{16'h01A0, 16'h01A0, 16'h0120, 16'h01A0, 16'h01A0};
  an_page_codec #(.LINK_TIMER_CYC(LT), .ABILITY(ABIL), .RF_SUPPORT(1'b1)) i_dut (
    .SYS_CLK(clk), .ARST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .XMIT(xmit), .RX_CFG_VALID(rxv), .RX_CFG_WORD(rxw), .SYNC_OK(sync), .IDLE_DETECT(idet),
    .CMPL_ACK(cack), .RESOLVE_FAIL(rfail), .TX_KIND(kind), .TX_CFG_WORD(txw),
    .RF_STATUS(rfst), .PAUSE_TX_EN(ptx), .PAUSE_RX_EN(prx));
  an_partner i_partner (.clk(clk), .rst_n(rst_n), .send(psend), .word(pword),
    .tx_word(txw), .valid(rxv), .rx_word(rxw));
  initial forever #50 clk = ~clk;
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    tick(4);
    rst_n <= 1;
    tick(3);
    // Reserved bits and the missing half duplex ability never go out
    apb(1, an_page_pkg::OFF_ADV, 32'h0000_8FFF);
    apb(1, an_page_pkg::OFF_CTRL, 32'h0000_0001);
    tick(3);
    chk("restart zeros", 0, txw);
    tick(LT + 4);
    chk("base page", 16'h81A0, txw);
    for (int i = 0; i < 9; i++) begin
      apb(1, an_page_pkg::OFF_ADV, {23'h0, rows[i][4], rows[i][5], 7'h20});
      xmit <= rows[i][9:8];
      pword <= {7'h0, rows[i][2], rows[i][3], 7'h20};
      psend <= 1;
      tick(4);
      psend <= 0;
      tick(4);
      chk("kind", rows[i][7:6], kind);
      chk("pause tx", rows[i][1], ptx);
      chk("pause rx", rows[i][0], prx);
    end
    // A differing word in the run restarts the match count
    psend <= 1;
    for (int i = 0; i < 5; i++) begin
      pword <= sq[i];
      tick(1);
    end
    psend <= 0;
    tick(5);
    chk("ack early", 0, txw[14]);
    psend <= 1;
    tick(1);
    psend <= 0;
    tick(5);
    chk("ack", 1, txw[14]);
    pword <= 16'h2020;
    psend <= 1;
    tick(3);
    psend <= 0;
    tick(3);
    chk("rf status", 1, rfst);
    sync <= 0;
    tick(2);
    chk("rf hidden", 0, rfst);
    sync <= 1;
    tick(2);
    chk("rf shown", 1, rfst);
    rfail <= 1;
    tick(4);
    chk("rf aneg", an_page_pkg::RF_AN_ERROR, txw[13:12]);
    rfail <= 0;
    idet <= 1;
    tick(1);
    idet <= 0;
    tick(4);
    chk("rf cleared", an_page_pkg::RF_OK, txw[13:12]);
    // Software may flag a fault of its own through the advertisement
    apb(1, an_page_pkg::OFF_ADV, 32'h0000_21A0);
    tick(2);
    chk("rf offline", an_page_pkg::RF_OFFLINE, txw[13:12]);
    pword <= 0;
    psend <= 1;
    tick(LT + 6);
    psend <= 0;
    tick(3);
    chk("rf link", an_page_pkg::RF_LINK_FAIL, txw[13:12]);
    apb(0, an_page_pkg::OFF_STATUS, 0);
    chk("status rf", an_page_pkg::RF_LINK_FAIL, q[1:0]);
    chk("status fault", 1, q[2]);
    apb(0, an_page_pkg::OFF_PARTNER, 0);
    chk("fault cleared", 0, rfst);
    // The partner had acknowledged, so its stored page carries Ack
    chk("partner page", 16'h6020, q);
    // A nonzero word ends the link failure so idle-detect can clear
    pword <= 16'h01A0;
    psend <= 1;
    tick(1);
    psend <= 0;
    tick(2);
    idet <= 1;
    tick(1);
    idet <= 0;
    tick(2);
    // Complete-ack freezes the word even though the advertisement changes
    cack <= 1;
    tick(1);
    cack <= 0;
    apb(1, an_page_pkg::OFF_ADV, 32'h0000_0020);
    tick(2);
    chk("held word", 16'h01A0, txw & ~an_page_pkg::ACK_MASK);
    tick(LT + 2);
    chk("new word", 16'h0020, txw & ~an_page_pkg::ACK_MASK);
    apb(1, an_page_pkg::OFF_CTRL, 32'h0000_0002);
    pword <= 16'h8001;
    psend <= 1;
    tick(3);
    psend <= 0;
    tick(5);
    chk("np ack", 1, txw[14]);
    tick(6);
    chk("np ack kept", 1, txw[14]);
    apb(1, an_page_pkg::OFF_NPTX, 32'h0000_8005);
    tick(3);
    chk("np word", 16'h8005, txw);
    apb(0, 8'h20, 0);
    chk("slverr", 1, e);
    chk("unmapped data", 0, q);
    // Clock enable low freezes the output registers
    ce <= 0;
    xmit <= 2'h0;
    tick(3);
    chk("frozen kind", 1, kind);
    ce <= 1;
    tick(2);
    chk("kind idle", 0, kind);
    // Reset in mid-run
    rst_n <= 0;
    tick(2);
    chk("reset word", 0, txw);
    rst_n <= 1;
    tick(4);
    apb(0, an_page_pkg::OFF_ADV, 0);
    chk("adv reset", an_page_pkg::ADV_RST, q);
    final_report();
  end
endmodule // tb_top
